// ==== rtl/etc_top.sv ====
// How it works
// - IPv4 header checksum is generated only when its enable is set.
// - TCP/UDP checksum is generated only when its enable is set.
// - VLAN insertion takes the frame word if valid, else the default.
// - VLAN tags are inserted only on frames taking the MAC path.
// - Back pressure raises carrier on 10/100 half duplex until cleared.
// - Received pause sets a status bit that clears when time elapses.
// - A pause request waits for the frame, sends pause, flags, clears.
// - Pause frames go out even when data is stopped or paused.
// - Each ring has a halt bit at its own index that blocks its DMA.
// - Writing one to a halt bit clears it and restarts the ring, unless error or exhaustion sets it in that cycle.
// - Halt bits set only on general error or an exhausted ring.
// - Graceful stop never sets a halt bit.
// - Bus, uncorrectable and zero-length errors halt transmission.
// - Pause time is the low half, extended parameter the high half.
// - The default VLAN word holds Ethertype, priority, CFI and VID.
`timescale 1ns/10ps
module etc_top
  import etc_pkg::*;
#(
  parameter int NUM_RINGS = 6,
  parameter int QCYC_1G = ETC_QCYC_1G,
  parameter int QCYC_100M = ETC_QCYC_100M,
  parameter int QCYC_10M = ETC_QCYC_10M
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic [2:0] frm_ring,
  input wire logic frm_ip_cs_req,
  input wire logic frm_l4_cs_req,
  input wire logic frm_vlan_valid,
  input wire logic [15:0] frm_vlan_word,
  input wire logic frm_mac_path,
  output logic mac_start,
  output logic mac_ip_cs_en,
  output logic mac_l4_cs_en,
  output logic mac_vlan_ins,
  output logic [31:0] mac_vlan_tag,
  input wire logic mac_done,
  output logic ctl_start,
  output logic [15:0] ctl_quanta,
  output logic [15:0] ctl_param,
  input wire logic ctl_done,
  input wire logic rx_pause_valid,
  input wire logic [15:0] rx_pause_quanta,
  input wire logic [1:0] link_speed,
  input wire logic link_half_duplex,
  output logic carrier_force,
  input wire logic dma_bus_err,
  input wire logic dma_ecc_err,
  input wire logic dma_zero_len,
  input wire logic [NUM_RINGS-1:0] dma_ring_empty,
  output logic [NUM_RINGS-1:0] ring_halted,
  output logic tx_gts
);
  if (NUM_RINGS < 1 || NUM_RINGS > 6) begin
    $error("etc_top: NUM_RINGS must be 1 to 6");
  end

  typedef struct packed {
    etc_fsm_t fsm;
    logic ip_en;
    logic l4_en;
    logic vlan_en;
    logic hdbp;
    logic pause_req;
    logic graceful_tx_stop;
    logic [31:0] pause_time_reg;
    logic [31:0] dfv;
    logic [ETC_EV_W-1:0] ev;
    logic [ETC_EV_W-1:0] mask;
    logic [31:0] rdata;
    logic mac_start;
    logic mac_ip;
    logic mac_l4;
    logic mac_vins;
    logic [31:0] mac_tag;
    logic ctl_start;
    logic [31:0] ctl_word;
    logic carrier;
    logic rxp_prev;
  } etc_top_t;

  localparam etc_top_t RST = '{
    fsm: ETC_ST_IDLE,
    pause_time_reg: ETC_RST_PAUSE_TIME,
    dfv: ETC_RST_VLAN,
    default: '0
  };

  etc_top_t s_q;
  etc_top_t s_d;
  logic gen_err;
  logic accept;
  logic [7:0] halted8;
  logic wr_tc;

  function automatic logic etc_hit(logic [7:0] a, logic stb,
                                   logic [7:0] off);
    return stb && (a == off);
  endfunction

  // ==========================================================
  // Sub-blocks
  etc_sub_if #(.NUM_RINGS(NUM_RINGS)) sub ();

  etc_pause_timer #(
    .QCYC_1G(QCYC_1G),
    .QCYC_100M(QCYC_100M),
    .QCYC_10M(QCYC_10M)
  ) u_pause (
    .clk(clk),
    .nrst(nrst),
    .pz(sub.pause_mp)
  );

  etc_ring_halt #(.NUM_RINGS(NUM_RINGS)) u_halt (
    .clk(clk),
    .nrst(nrst),
    .hl(sub.halt_mp)
  );

  assign sub.pz_load = rx_pause_valid;
  assign sub.pz_quanta = rx_pause_quanta;
  assign sub.pz_speed = link_speed;
  assign gen_err = dma_bus_err | dma_ecc_err | dma_zero_len;
  assign sub.hl_gen_err = gen_err;
  assign sub.hl_empty = dma_ring_empty;
  assign sub.hl_clr = etc_hit(reg_addr, reg_wr, ETC_OFF_TX_STATUS) ?
    reg_wdata[NUM_RINGS-1:0] : '0;

  // ==========================================================
  // Frame admission
  assign wr_tc = etc_hit(reg_addr, reg_wr, ETC_OFF_TX_CONTROL);
  // Rings beyond the configured count look halted
  assign halted8 = {{(8-NUM_RINGS){1'b1}}, sub.hl_halted};
  assign frm_ready = (s_q.fsm == ETC_ST_IDLE) && !s_q.pause_req &&
    !s_q.graceful_tx_stop && !sub.pz_active && !halted8[frm_ring];
  assign accept = frm_valid && frm_ready;

  // ==========================================================
  // Sequencer and registers
  always_comb begin
    logic pause_clr;
    logic [ETC_EV_W-1:0] ev_set;
    logic [ETC_EV_W-1:0] ev_clr;
    logic [31:0] rd;
    pause_clr = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    rd = 32'h0000_0000;
    s_d = s_q;
    s_d.mac_start = 1'b0;
    s_d.ctl_start = 1'b0;
    s_d.rxp_prev = sub.pz_active;

    unique case (s_q.fsm)
      ETC_ST_IDLE: begin
        if (s_q.pause_req) begin
          s_d.fsm = ETC_ST_PAUSE;
          s_d.ctl_start = 1'b1;
          s_d.ctl_word = s_q.pause_time_reg;
        end else if (accept) begin
          s_d.fsm = ETC_ST_DATA;
          s_d.mac_start = 1'b1;
          s_d.mac_ip = s_q.ip_en & frm_ip_cs_req;
          s_d.mac_l4 = s_q.l4_en & frm_l4_cs_req;
          s_d.mac_vins = s_q.vlan_en & frm_mac_path;
          s_d.mac_tag = {s_q.dfv[31:16],
            frm_vlan_valid ? frm_vlan_word : s_q.dfv[15:0]};
        end
      end
      ETC_ST_DATA: begin
        if (mac_done) begin
          s_d.fsm = ETC_ST_IDLE;
        end
      end
      ETC_ST_PAUSE: begin
        if (ctl_done) begin
          s_d.fsm = ETC_ST_IDLE;
          pause_clr = 1'b1;
          ev_set[ETC_EV_TX_CTL] = 1'b1;
        end
      end
      default: s_d.fsm = ETC_ST_IDLE;
    endcase

    if (pause_clr) begin
      s_d.pause_req = 1'b0;
    end
    if (wr_tc) begin
      s_d.ip_en = reg_wdata[ETC_BIT_IP_CS];
      s_d.l4_en = reg_wdata[ETC_BIT_L4_CS];
      s_d.vlan_en = reg_wdata[ETC_BIT_VLAN_INS];
      s_d.hdbp = reg_wdata[ETC_BIT_HD_BP];
      if (reg_wdata[ETC_BIT_TX_PAUSE]) begin
        s_d.pause_req = 1'b1;
      end
    end
    if (etc_hit(reg_addr, reg_wr, ETC_OFF_PAUSE_TIME)) begin
      s_d.pause_time_reg = reg_wdata;
    end
    if (etc_hit(reg_addr, reg_wr, ETC_OFF_DEFAULT_VLAN)) begin
      s_d.dfv = reg_wdata;
    end
    if (etc_hit(reg_addr, reg_wr, ETC_OFF_DMA_CONTROL)) begin
      s_d.graceful_tx_stop = reg_wdata[ETC_BIT_GTS];
    end
    if (etc_hit(reg_addr, reg_wr, ETC_OFF_EVENT_MASK)) begin
      s_d.mask = reg_wdata[ETC_EV_W-1:0];
    end
    if (etc_hit(reg_addr, reg_wr, ETC_OFF_EVENT)) begin
      ev_clr = reg_wdata[ETC_EV_W-1:0];
    end

    ev_set[ETC_EV_TX_ERR] = gen_err;
    ev_set[ETC_EV_RX_PAUSE] = sub.pz_active & ~s_q.rxp_prev;
    s_d.ev = (s_q.ev & ~ev_clr) | ev_set;

    s_d.carrier = s_q.hdbp && link_half_duplex &&
      (link_speed != ETC_SPD_1G);

    unique case (reg_addr)
      ETC_OFF_TX_CONTROL: begin
        rd[ETC_BIT_IP_CS] = s_q.ip_en;
        rd[ETC_BIT_L4_CS] = s_q.l4_en;
        rd[ETC_BIT_VLAN_INS] = s_q.vlan_en;
        rd[ETC_BIT_HD_BP] = s_q.hdbp;
        rd[ETC_BIT_RX_PAUSE] = sub.pz_active;
        rd[ETC_BIT_TX_PAUSE] = s_q.pause_req;
      end
      ETC_OFF_TX_STATUS: rd[NUM_RINGS-1:0] = sub.hl_halted;
      ETC_OFF_PAUSE_TIME: rd = s_q.pause_time_reg;
      ETC_OFF_DEFAULT_VLAN: rd = s_q.dfv;
      ETC_OFF_DMA_CONTROL: rd[ETC_BIT_GTS] = s_q.graceful_tx_stop;
      ETC_OFF_EVENT: rd[ETC_EV_W-1:0] = s_q.ev;
      ETC_OFF_EVENT_MASK: rd[ETC_EV_W-1:0] = s_q.mask;
      default: rd = 32'h0000_0000;
    endcase
    s_d.rdata = reg_rd ? rd : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = s_q.rdata;
  assign irq = |(s_q.ev & s_q.mask);
  assign mac_start = s_q.mac_start;
  assign mac_ip_cs_en = s_q.mac_ip;
  assign mac_l4_cs_en = s_q.mac_l4;
  assign mac_vlan_ins = s_q.mac_vins;
  assign mac_vlan_tag = s_q.mac_tag;
  assign ctl_start = s_q.ctl_start;
  assign ctl_quanta = s_q.ctl_word[15:0];
  assign ctl_param = s_q.ctl_word[31:16];
  assign carrier_force = s_q.carrier;
  assign ring_halted = sub.hl_halted;
  assign tx_gts = s_q.graceful_tx_stop;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ip_gate;
    mac_start |-> mac_ip_cs_en == $past(s_q.ip_en && frm_ip_cs_req);
  endproperty
  a_ip_gate: assert property (p_ip_gate)
    else $error("IPv4 checksum enable not gated");

  property p_l4_gate;
    mac_start |-> mac_l4_cs_en == $past(s_q.l4_en && frm_l4_cs_req);
  endproperty
  a_l4_gate: assert property (p_l4_gate)
    else $error("L4 checksum enable not gated");

  property p_vlan_word;
    mac_start |-> mac_vlan_tag[15:0] == ($past(frm_vlan_valid) ?
      $past(frm_vlan_word) : $past(s_q.dfv[15:0]));
  endproperty
  a_vlan_word: assert property (p_vlan_word)
    else $error("VLAN control word from wrong source");

  property p_vlan_path;
    mac_start && mac_vlan_ins |-> $past(frm_mac_path && s_q.vlan_en);
  endproperty
  a_vlan_path: assert property (p_vlan_path)
    else $error("VLAN insert off the MAC path");

  property p_vlan_type;
    mac_start |-> mac_vlan_tag[31:16] == $past(s_q.dfv[31:16]);
  endproperty
  a_vlan_type: assert property (p_vlan_type)
    else $error("inserted Ethertype not from default word");

  property p_backpressure;
    s_q.hdbp && link_half_duplex && link_speed != ETC_SPD_1G
      ##1 s_q.hdbp |-> carrier_force;
  endproperty
  a_backpressure: assert property (p_backpressure)
    else $error("back pressure not applied");

  property p_rx_pause;
    rx_pause_valid && rx_pause_quanta != 16'h0000 |=> !frm_ready;
  endproperty
  a_rx_pause: assert property (p_rx_pause)
    else $error("data admitted during received pause");

  property p_pause_send;
    s_q.fsm == ETC_ST_IDLE && s_q.pause_req
      |=> ctl_start && ctl_quanta == $past(s_q.pause_time_reg[15:0]);
  endproperty
  a_pause_send: assert property (p_pause_send)
    else $error("pending pause frame not started");

  property p_pause_wait;
    s_q.fsm == ETC_ST_DATA && !mac_done |=> !ctl_start;
  endproperty
  a_pause_wait: assert property (p_pause_wait)
    else $error("pause frame cut into a data frame");

  property p_pause_done;
    s_q.fsm == ETC_ST_PAUSE && ctl_done && !wr_tc
      |=> !s_q.pause_req && s_q.ev[ETC_EV_TX_CTL] &&
          s_q.fsm == ETC_ST_IDLE;
  endproperty
  a_pause_done: assert property (p_pause_done)
    else $error("pause completion not flagged or cleared");

  property p_halt_block;
    frm_valid && halted8[frm_ring] |-> !frm_ready;
  endproperty
  a_halt_block: assert property (p_halt_block)
    else $error("frame admitted from halted ring");

  property p_tx_err;
    gen_err |=> s_q.ev[ETC_EV_TX_ERR] && (&ring_halted);
  endproperty
  a_tx_err: assert property (p_tx_err)
    else $error("transmit error did not halt and flag");

  property p_reserved;
    reg_rd && reg_addr == ETC_OFF_TX_CONTROL
      |=> (reg_rdata & ~ETC_TC_USED) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits read nonzero");
endmodule

// ==== rtl/etc_pkg.sv ====
package etc_pkg;
  // ==========================================================
  // Clock and pause quantum timing
  localparam int ETC_CLK_PERIOD_NS = 4;
  localparam int ETC_QUANTUM_BITS = 512;
  localparam int ETC_BIT_NS_1G = 1;
  localparam int ETC_BIT_NS_100M = 10;
  localparam int ETC_BIT_NS_10M = 100;
  localparam int ETC_QCYC_1G = (ETC_QUANTUM_BITS * ETC_BIT_NS_1G
    + ETC_CLK_PERIOD_NS - 1) / ETC_CLK_PERIOD_NS;
  localparam int ETC_QCYC_100M = (ETC_QUANTUM_BITS * ETC_BIT_NS_100M
    + ETC_CLK_PERIOD_NS - 1) / ETC_CLK_PERIOD_NS;
  localparam int ETC_QCYC_10M = (ETC_QUANTUM_BITS * ETC_BIT_NS_10M
    + ETC_CLK_PERIOD_NS - 1) / ETC_CLK_PERIOD_NS;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ETC_OFF_TX_CONTROL = 8'h00;
  localparam logic [7:0] ETC_OFF_TX_STATUS = 8'h04;
  localparam logic [7:0] ETC_OFF_PAUSE_TIME = 8'h08;
  localparam logic [7:0] ETC_OFF_DEFAULT_VLAN = 8'h0C;
  localparam logic [7:0] ETC_OFF_DMA_CONTROL = 8'h10;
  localparam logic [7:0] ETC_OFF_EVENT = 8'h14;
  localparam logic [7:0] ETC_OFF_EVENT_MASK = 8'h18;

  // ==========================================================
  // Field positions
  localparam int ETC_BIT_IP_CS = 17;
  localparam int ETC_BIT_L4_CS = 18;
  localparam int ETC_BIT_VLAN_INS = 19;
  localparam int ETC_BIT_HD_BP = 20;
  localparam int ETC_BIT_RX_PAUSE = 27;
  localparam int ETC_BIT_TX_PAUSE = 28;
  localparam int ETC_BIT_GTS = 28;
  localparam int ETC_EV_TX_ERR = 0;
  localparam int ETC_EV_TX_CTL = 1;
  localparam int ETC_EV_RX_PAUSE = 2;
  localparam int ETC_EV_W = 3;
  localparam logic [31:0] ETC_TC_USED = 32'h181E_0000;

  // ==========================================================
  // Reset values
  localparam logic [31:0] ETC_RST_PAUSE_TIME = 32'h0000_0000;
  localparam logic [31:0] ETC_RST_VLAN = 32'h8100_0000;

  // ==========================================================
  // Link speed codes and sequencer states
  localparam logic [1:0] ETC_SPD_10M = 2'h0;
  localparam logic [1:0] ETC_SPD_100M = 2'h1;
  localparam logic [1:0] ETC_SPD_1G = 2'h2;

  typedef enum logic [2:0] {
    ETC_ST_IDLE = 3'h1,
    ETC_ST_DATA = 3'h2,
    ETC_ST_PAUSE = 3'h4
  } etc_fsm_t;
endpackage

// ==== rtl/etc_sub_if.sv ====
`timescale 1ns/10ps
interface etc_sub_if #(parameter int NUM_RINGS = 6);
  logic pz_load;
  logic [15:0] pz_quanta;
  logic [1:0] pz_speed;
  logic pz_active;
  logic hl_gen_err;
  logic [NUM_RINGS-1:0] hl_empty;
  logic [NUM_RINGS-1:0] hl_clr;
  logic [NUM_RINGS-1:0] hl_halted;
  modport pause_mp(input pz_load, pz_quanta, pz_speed, output pz_active);
  modport halt_mp(input hl_gen_err, hl_empty, hl_clr, output hl_halted);
endinterface

// ==== rtl/etc_pause_timer.sv ====
`timescale 1ns/10ps
module etc_pause_timer
  import etc_pkg::*;
#(
  parameter int QCYC_1G = ETC_QCYC_1G,
  parameter int QCYC_100M = ETC_QCYC_100M,
  parameter int QCYC_10M = ETC_QCYC_10M
) (
  input wire logic clk,
  input wire logic nrst,
  etc_sub_if.pause_mp pz
);
  localparam int CW = 14;
  typedef struct packed {
    logic active;
    logic [15:0] left;
    logic [CW-1:0] cyc;
  } etc_pt_t;
  etc_pt_t s_q;
  etc_pt_t s_d;
  logic [CW-1:0] lim;

  if (QCYC_1G < 1 || QCYC_100M < 1 || QCYC_10M < 1 ||
      QCYC_1G >= 2**CW || QCYC_100M >= 2**CW || QCYC_10M >= 2**CW) begin
    $error("etc_pause_timer: quantum cycle count out of range");
  end

  // ==========================================================
  // Quantum countdown
  always_comb begin
    unique case (pz.pz_speed)
      ETC_SPD_1G: lim = CW'(QCYC_1G - 1);
      ETC_SPD_100M: lim = CW'(QCYC_100M - 1);
      default: lim = CW'(QCYC_10M - 1);
    endcase
    s_d = s_q;
    if (pz.pz_load) begin
      s_d.active = (pz.pz_quanta != 16'h0000);
      s_d.left = pz.pz_quanta;
      s_d.cyc = '0;
    end else if (s_q.active) begin
      if (s_q.cyc >= lim) begin
        s_d.cyc = '0;
        s_d.left = s_q.left - 16'h0001;
        if (s_q.left == 16'h0001) begin
          s_d.active = 1'b0;
        end
      end else begin
        s_d.cyc = CW'(s_q.cyc + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pz.pz_active = s_q.active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_pause_start;
    pz.pz_load && pz.pz_quanta != 16'h0000 |=> pz.pz_active;
  endproperty
  a_pause_start: assert property (p_pause_start)
    else $error("pause not started by received pause frame");

  property p_pause_end;
    s_q.active && !pz.pz_load && s_q.left == 16'h0001 && s_q.cyc >= lim
      |=> !pz.pz_active;
  endproperty
  a_pause_end: assert property (p_pause_end)
    else $error("pause did not end after last quantum");
endmodule

// ==== rtl/etc_ring_halt.sv ====
`timescale 1ns/10ps
module etc_ring_halt
  import etc_pkg::*;
#(
  parameter int NUM_RINGS = 6
) (
  input wire logic clk,
  input wire logic nrst,
  etc_sub_if.halt_mp hl
);
  typedef struct packed {
    logic [NUM_RINGS-1:0] halted;
  } etc_rh_t;
  etc_rh_t s_q;
  etc_rh_t s_d;
  logic [NUM_RINGS-1:0] set_v;

  // ==========================================================
  // Halt flags, set wins over a write-one clear
  // error or exhaustion
  assign set_v = {NUM_RINGS{hl.hl_gen_err}} | hl.hl_empty;

  always_comb begin
    s_d = s_q;
    s_d.halted = set_v | (s_q.halted & ~hl.hl_clr);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hl.hl_halted = s_q.halted;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_halt_err;
    hl.hl_gen_err |=> &hl.hl_halted;
  endproperty
  a_halt_err: assert property (p_halt_err)
    else $error("general error did not halt every ring");

  property p_halt_clr;
    (hl.hl_clr & ~set_v) != '0
      |=> (hl.hl_halted & $past(hl.hl_clr & ~set_v)) == '0;
  endproperty
  a_halt_clr: assert property (p_halt_clr)
    else $error("write of one did not clear ring halt");

  property p_halt_cause;
    1'b1 |=> (hl.hl_halted & ~$past(hl.hl_halted) & ~$past(set_v)) == '0;
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("ring halt set without error or exhaustion");
endmodule

// ==== verif/etc_far_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// MAC and link partner: answers each start after dly cycles
module etc_far_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mac_start,
  input wire logic ctl_start,
  input wire logic [31:0] dly,
  output logic mac_done,
  output logic ctl_done,
  output logic mbusy
);
  int mc;
  int cc;
  assign mbusy = (mc != 0);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mc <= 0;
      cc <= 0;
      mac_done <= 1'h0;
      ctl_done <= 1'h0;
    end else begin
      mac_done <= (mc == 1);
      ctl_done <= (cc == 1);
      if (mac_start) begin
        mc <= dly;
      end else if (mc != 0) begin
        mc <= mc - 1;
      end
      if (ctl_start) begin
        cc <= dly;
      end else if (cc != 0) begin
        cc <= cc - 1;
      end
    end
  end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import etc_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, irq, frm_valid, frm_ready, mbusy;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mac_vlan_tag, rd_q;
  logic [2:0] frm_ring;
  logic frm_ip_cs_req, frm_l4_cs_req, frm_vlan_valid, frm_mac_path;
  logic [15:0] frm_vlan_word, ctl_quanta, ctl_param, rx_pause_quanta;
  logic mac_start, mac_ip_cs_en, mac_l4_cs_en, mac_vlan_ins, mac_done;
  logic ctl_start, ctl_done, rx_pause_valid, link_half_duplex;
  logic carrier_force, dma_bus_err, dma_ecc_err, dma_zero_len, tx_gts;
  logic [1:0] link_speed;
  logic [5:0] dma_ring_empty, ring_halted;
  int dly, n_errors, num_checks;

  etc_top #(.QCYC_1G(2), .QCYC_100M(3), .QCYC_10M(4)) i_dut (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .frm_valid, .frm_ready, .frm_ring, .frm_ip_cs_req,
    .frm_l4_cs_req, .frm_vlan_valid, .frm_vlan_word, .frm_mac_path,
    .mac_start, .mac_ip_cs_en, .mac_l4_cs_en, .mac_vlan_ins,
    .mac_vlan_tag, .mac_done, .ctl_start, .ctl_quanta, .ctl_param,
    .ctl_done, .rx_pause_valid, .rx_pause_quanta, .link_speed,
    .link_half_duplex, .carrier_force, .dma_bus_err, .dma_ecc_err,
    .dma_zero_len, .dma_ring_empty, .ring_halted, .tx_gts);
  etc_far_model i_far (.clk, .nrst, .mac_start, .ctl_start, .dly,
    .mac_done, .ctl_done, .mbusy);

  // ==========================================================
  // Shared tasks
  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 rd_q = reg_rdata;
  endtask
  // Flags are {ip, l4, vlan valid, mac path}
  task automatic snd(input logic [2:0] r, input logic [3:0] f,
                     input logic [15:0] w);
    int i;
    @(posedge clk);
    frm_ring <= r;
    {frm_ip_cs_req, frm_l4_cs_req, frm_vlan_valid, frm_mac_path} <= f;
    frm_vlan_word <= w;
    frm_valid <= 1'h1;
    i = 0;
    #1;
    while (frm_ready !== 1'h1 && i < 60) begin
      @(posedge clk);
      #1;
      i++;
    end
    @(posedge clk);
    frm_valid <= 1'h0;
    #1 chk("mac_start", 1, mac_start);
  endtask
  task automatic wctl();
    int i;
    for (i = 0; i < 100 && ctl_start !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("ctl_start", 1, ctl_start);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(ETC_OFF_TX_CONTROL);
    chk("ctrl rst", 0, rd_q);
    rd(ETC_OFF_PAUSE_TIME);
    chk("pause rst", 0, rd_q);
    rd(ETC_OFF_DEFAULT_VLAN);
    chk("vlan rst", 32'h8100_0000, rd_q);
    wr(ETC_OFF_TX_CONTROL, 32'hE7FF_FFFF);
    rd(ETC_OFF_TX_CONTROL);
    chk("ctrl rsvd", 32'h001E_0000, rd_q);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk("unmapped", 0, rd_q);
    wr(ETC_OFF_TX_CONTROL, 32'h0000_0000);
    $display("done regs");
  endtask
  task automatic t_offload();
    for (int k = 0; k < 4; k++) begin
      wr(ETC_OFF_TX_CONTROL, (k << 17) | 32'h0008_0000);
      snd(3'h0, 4'hF, 16'h0123);
      chk("ip_cs", k % 2, mac_ip_cs_en);
      chk("l4_cs", k / 2, mac_l4_cs_en);
      chk("tag frm", 32'h8100_0123, mac_vlan_tag);
    end
    wr(ETC_OFF_DEFAULT_VLAN, 32'h8100_A5A5);
    snd(3'h1, 4'h1, 16'h0123);
    chk("tag dflt", 32'h8100_A5A5, mac_vlan_tag);
    snd(3'h3, 4'h2, 16'h0123);
    chk("no mac path", 0, mac_vlan_ins);
    wr(ETC_OFF_TX_CONTROL, 32'h0000_0000);
    snd(3'h0, 4'hF, 16'h0123);
    chk("vlan off", 0, mac_vlan_ins);
    $display("done offload");
  endtask
  task automatic t_bp();
    wr(ETC_OFF_TX_CONTROL, 32'h0010_0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      link_speed <= 2'(i % 3);
      link_half_duplex <= 1'(i / 3);
      repeat (3) @(posedge clk);
      #1 chk("carrier", (i / 3 == 1) && (i % 3 != 2), carrier_force);
    end
    wr(ETC_OFF_TX_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1 chk("carrier off", 0, carrier_force);
    $display("done backpressure");
  endtask
  task automatic t_rxp();
    @(posedge clk);
    link_speed <= ETC_SPD_1G;
    rx_pause_valid <= 1'h1;
    rx_pause_quanta <= 16'h0004;
    @(posedge clk);
    rx_pause_valid <= 1'h0;
    frm_ring <= 3'h0;
    frm_valid <= 1'h1;
    @(posedge clk);
    #1 chk("rx paused ready", 0, frm_ready);
    @(posedge clk);
    frm_valid <= 1'h0;
    rd(ETC_OFF_TX_CONTROL);
    chk("rx pause on", 32'h0800_0000, rd_q);
    repeat (12) @(posedge clk);
    rd(ETC_OFF_TX_CONTROL);
    chk("rx pause off", 0, rd_q);
    wr(ETC_OFF_EVENT, 32'h0000_0007);
    $display("done rx pause");
  endtask
  task automatic t_txp();
    wr(ETC_OFF_PAUSE_TIME, 32'hABCD_0012);
    wr(ETC_OFF_EVENT_MASK, 32'h0000_0002);
    dly <= 20;
    snd(3'h0, 4'h1, 16'h0000);
    wr(ETC_OFF_TX_CONTROL, 32'h1000_0000);
    wctl();
    chk("frame done first", 0, mbusy);
    chk("quanta", 32'h0012, ctl_quanta);
    chk("param", 32'hABCD, ctl_param);
    repeat (25) @(posedge clk);
    rd(ETC_OFF_TX_CONTROL);
    chk("req cleared", 0, rd_q);
    chk("irq on", 1, irq);
    wr(ETC_OFF_EVENT, 32'h0000_0002);
    #1 chk("irq off", 0, irq);
    dly <= 3;
    wr(ETC_OFF_DMA_CONTROL, 32'h1000_0000);
    #1 chk("gts", 1, tx_gts);
    wr(ETC_OFF_TX_CONTROL, 32'h1000_0000);
    wctl();
    repeat (6) @(posedge clk);
    wr(ETC_OFF_DMA_CONTROL, 32'h0000_0000);
    wr(ETC_OFF_EVENT, 32'h0000_0007);
    $display("done tx pause");
  endtask
  task automatic t_halt();
    @(posedge clk);
    dma_ring_empty <= 6'h04;
    @(posedge clk);
    dma_ring_empty <= 6'h00;
    #1 chk("halt ring2", 32'h04, ring_halted);
    rd(ETC_OFF_TX_STATUS);
    chk("status", 32'h04, rd_q);
    frm_ring <= 3'h2;
    frm_valid <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk("halted ready", 0, frm_ready);
    @(posedge clk);
    frm_valid <= 1'h0;
    wr(ETC_OFF_TX_STATUS, 32'h0000_0000);
    #1 chk("w0 keeps", 32'h04, ring_halted);
    wr(ETC_OFF_TX_STATUS, 32'h0000_0004);
    #1 chk("w1 clears", 0, ring_halted);
    for (int e = 0; e < 3; e++) begin
      @(posedge clk);
      {dma_bus_err, dma_ecc_err, dma_zero_len} <= 3'(4 >> e);
      @(posedge clk);
      {dma_bus_err, dma_ecc_err, dma_zero_len} <= 3'h0;
      #1 chk("halt all", 32'h3F, ring_halted);
      wr(ETC_OFF_TX_STATUS, 32'h0000_003F);
      #1 chk("halt clr", 0, ring_halted);
    end
    wr(ETC_OFF_DMA_CONTROL, 32'h1000_0000);
    repeat (3) @(posedge clk);
    #1 chk("gts no halt", 0, ring_halted);
    wr(ETC_OFF_DMA_CONTROL, 32'h0000_0000);
    $display("done halt");
  endtask

  // ==========================================================
  // Run control
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    {nrst, reg_wr, reg_rd, frm_valid, frm_ip_cs_req, frm_l4_cs_req} = '0;
    {frm_vlan_valid, frm_mac_path, rx_pause_valid, link_half_duplex} = '0;
    {dma_bus_err, dma_ecc_err, dma_zero_len} = '0;
    {reg_addr, reg_wdata, frm_ring, frm_vlan_word} = '0;
    {rx_pause_quanta, link_speed, dma_ring_empty} = '0;
    dly = 3;
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    t_regs();
    t_offload();
    t_bp();
    t_rxp();
    t_txp();
    t_halt();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
